// File: hdl/mnd_core.v
`timescale 1ns/1ps
`include "mnd_defines.vh"
// What this block does
// RQ1 - Move file register copies value unchanged
// RQ2 - Destination bit zero writes working register
// RQ3 - Destination bit one rewrites same file
// RQ4 - Move file register sets zero flag
// RQ5 - Idle pattern decoded, don't-care bits ignored
// RQ6 - Idle does nothing after decode phase
// RQ7 - Interrupt return pops stack in Q4
// RQ8 - Interrupt return sets irq enable Q3
// RQ9 - Interrupt return second cycle is idle
// RQ10 - Store working copies W, no flags
module mnd_core (
  input wire clock_i,
  input wire rst_i,
  input wire [`MND_IW-1:0] instr_i,
  input wire [`MND_DW-1:0] file_rdata_i,
  input wire [`MND_PCW-1:0] stack_top_i,
  output reg [`MND_AW-1:0] file_addr_o,
  output reg [`MND_DW-1:0] file_wdata_o,
  output reg file_we_o,
  output reg file_re_o,
  output reg [`MND_DW-1:0] working_o,
  output reg zero_flag_o,
  output reg global_irq_enable_o,
  output reg stack_pop_o,
  output reg pc_load_o,
  output reg [`MND_PCW-1:0] pc_o,
  output reg [1:0] phase_o,
  output reg fetch_o
);
  // ==========================================
  // Decode functions
  localparam K_NONE = 3'h0;
  localparam K_MOVEF = 3'h1;
  localparam K_STOREW = 3'h2;
  localparam K_IDLE = 3'h3;
  localparam K_IRET = 3'h4;
  function [2:0] kind_of;
    input [`MND_IW-1:0] iw;
    begin
      if (iw[`MND_OP_HI:`MND_OP_LO] == `MND_OP_MOVEF) begin
        kind_of = K_MOVEF; // RQ1
      end else if (iw[`MND_OP_HI:`MND_OP_LO] == `MND_OP_ZERO && iw[`MND_D_BIT]) begin
        kind_of = K_STOREW; // RQ10
      end else if ((iw & `MND_IDLE_MASK) == `MND_IDLE_VAL) begin
        kind_of = K_IDLE; // RQ5
      end else if (iw == `MND_IRET_VAL) begin
        kind_of = K_IRET;
      end else begin
        kind_of = K_NONE;
      end
    end
  endfunction
  // Only the two file moves touch the register file
  function uses_file;
    input [2:0] k;
    begin
      uses_file = (k == K_MOVEF) || (k == K_STOREW);
    end
  endfunction
  // ==========================================
  // Phase and state
  wire [1:0] ph;
  wire ph_last;
  mnd_phase u_phase (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .phase_o(ph),
    .last_o(ph_last)
  );
  reg [`MND_IW-1:0] ir_q;
  reg [2:0] kind_q;
  reg flush_q;
  reg [`MND_DW-1:0] data_q;
  // ==========================================
  // Zero detect, one OR stage per data bit
  // Chain keeps the flag logic one OR per bit, no wide reduction
  wire [`MND_DW-1:0] any_chain;
  genvar gi;
  generate
    for (gi = 0; gi < `MND_DW; gi = gi + 1) begin : g_zero
      if (gi == 0) begin : g_first
        assign any_chain[gi] = data_q[gi];
      end else begin : g_rest
        assign any_chain[gi] = any_chain[gi-1] | data_q[gi];
      end
    end
  endgenerate
  wire data_zero = ~any_chain[`MND_DW-1];
  // ==========================================
  // Instruction register and decoded kind
  always @(posedge clock_i) begin
    if (rst_i) begin
      ir_q <= `MND_IDLE_VAL;
      kind_q <= K_IDLE;
    end else if (ph == `MND_Q1) begin
      // Flushed cycle after a return is forced idle
      // Unknown words decode as none and behave as idle
      ir_q <= instr_i;
      kind_q <= flush_q ? K_IDLE : kind_of(instr_i); // RQ9
    end
  end
  // ==========================================
  // Second cycle of a return is idle
  always @(posedge clock_i) begin
    if (rst_i) begin
      flush_q <= 1'b0;
    end else begin
      case (ph)
        `MND_Q1: begin
          flush_q <= 1'b0;
        end
        `MND_Q4: begin
          flush_q <= (kind_q == K_IRET); // RQ9
        end
        default: begin
          flush_q <= flush_q;
        end
      endcase
    end
  end
  // ==========================================
  // Data latched in the processing quarter
  always @(posedge clock_i) begin
    if (rst_i) begin
      data_q <= `MND_ZERO8;
    end else if (ph == `MND_Q3 && uses_file(kind_q)) begin
      data_q <= (kind_q == K_STOREW) ? working_o : file_rdata_i; // RQ1
    end
  end
  // ==========================================
  // Register file port
  always @(posedge clock_i) begin
    if (rst_i) begin
      file_addr_o <= {`MND_AW{1'b0}};
      file_wdata_o <= `MND_ZERO8;
      file_we_o <= 1'b0;
      file_re_o <= 1'b0;
    end else begin
      file_we_o <= 1'b0;
      file_re_o <= 1'b0;
      case (ph)
        `MND_Q1: begin
          file_addr_o <= instr_i[`MND_F_HI:`MND_F_LO];
        end
        `MND_Q2: begin
          file_re_o <= uses_file(kind_q); // RQ1
        end
        `MND_Q4: begin
          // Move with d set writes the same value back, a register test
          if ((kind_q == K_MOVEF && ir_q[`MND_D_BIT]) || kind_q == K_STOREW) begin
            file_wdata_o <= data_q; // RQ3 RQ10
            file_we_o <= 1'b1;
          end
        end
        default: begin
          // Idle and unknown words read and write nothing
          file_we_o <= 1'b0; // RQ6
        end
      endcase
    end
  end
  // ==========================================
  // Working register and zero flag
  // Store-to-file leaves the flag alone so a copy never disturbs a test
  always @(posedge clock_i) begin
    if (rst_i) begin
      working_o <= `MND_ZERO8;
      zero_flag_o <= 1'b0;
    end else if (ph == `MND_Q4 && kind_q == K_MOVEF) begin
      zero_flag_o <= data_zero; // RQ4
      if (!ir_q[`MND_D_BIT]) begin
        working_o <= data_q; // RQ2
      end
    end
  end
  // ==========================================
  // Interrupt enable
  // Cleared here only by reset; the interrupt logic elsewhere owns the clear
  always @(posedge clock_i) begin
    if (rst_i) begin
      global_irq_enable_o <= 1'b0;
    end else if (ph == `MND_Q3 && kind_q == K_IRET) begin
      global_irq_enable_o <= 1'b1; // RQ8
    end
  end
  // ==========================================
  // Stack pop and program counter
  // A return skips the increment; the loaded top replaces the count
  always @(posedge clock_i) begin
    if (rst_i) begin
      stack_pop_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_o <= `MND_PC_RST;
    end else begin
      stack_pop_o <= 1'b0;
      pc_load_o <= 1'b0;
      if (ph == `MND_Q4) begin
        if (kind_q == K_IRET) begin
          stack_pop_o <= 1'b1; // RQ7
          pc_load_o <= 1'b1;
          pc_o <= stack_top_i;
        end else begin
          pc_o <= pc_o + `MND_PC_INC;
        end
      end
    end
  end
  // ==========================================
  // Phase and fetch strobes
  // Fetch is registered from the last quarter, so it is high in the first quarter of the next cycle
  always @(posedge clock_i) begin
    if (rst_i) begin
      phase_o <= `MND_Q1;
      fetch_o <= 1'b0;
    end else begin
      phase_o <= ph;
      fetch_o <= ph_last;
    end
  end
endmodule // mnd_core

// File: hdl/mnd_defines.vh
`ifndef MND_DEFINES_VH
`define MND_DEFINES_VH
// ==========================================
// Instruction word layout
`define MND_IW 14
`define MND_DW 8
`define MND_AW 7
`define MND_PCW 13
`define MND_OP_HI 13
`define MND_OP_LO 8
`define MND_D_BIT 7
`define MND_F_HI 6
`define MND_F_LO 0
// ==========================================
// Opcodes and patterns
`define MND_OP_MOVEF 6'h08
`define MND_OP_ZERO 6'h00
`define MND_IDLE_MASK 14'h3f9f
`define MND_IDLE_VAL 14'h0000
`define MND_IRET_VAL 14'h0009
// ==========================================
// Quarter phases
`define MND_Q1 2'h0
`define MND_Q2 2'h1
`define MND_Q3 2'h2
`define MND_Q4 2'h3
`define MND_ZERO8 8'h00
`define MND_PC_RST 13'h0000
`define MND_PC_INC 13'h0001
`define MND_PH_INC 2'h1
`endif

// File: hdl/mnd_phase.v
`timescale 1ns/1ps
`include "mnd_defines.vh"
// ==========================================
// Quarter phase counter, one clock per quarter
module mnd_phase (
  input wire clock_i,
  input wire rst_i,
  output wire [1:0] phase_o,
  output wire last_o
);
  reg [1:0] phase_q;
  always @(posedge clock_i) begin
    if (rst_i) begin
      phase_q <= `MND_Q1;
    end else begin
      phase_q <= phase_q + `MND_PH_INC;
    end
  end
  assign phase_o = phase_q;
  assign last_o = (phase_q == `MND_Q4);
endmodule // mnd_phase

// File: verif/mnd_core_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module mnd_core_chk (
  input wire clock_i,
  input wire rst_i,
  input wire [13:0] instr_i,
  input wire [7:0] file_rdata_i,
  input wire [12:0] stack_top_i,
  input wire [7:0] file_wdata_o,
  input wire file_we_o,
  input wire file_re_o,
  input wire [7:0] working_o,
  input wire zero_flag_o,
  input wire global_irq_enable_o,
  input wire stack_pop_o,
  input wire pc_load_o,
  input wire [12:0] pc_o,
  input wire [1:0] phase_o
);
  reg run_q = 1'b0;
  reg iret_q = 1'b0;
  wire tk = run_q && phase_o == 2'h0;
  // Word in the cycle after a return is skipped, so it must not trigger checks
  wire dk = tk && !iret_q;
  always @(posedge clock_i) begin
    run_q <= !rst_i;
    if (rst_i || tk) iret_q <= tk && instr_i == 14'h0009 && !iret_q;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_move_w: assert property (dk && instr_i[13:7] == 7'h10 |-> ##3
    working_o == $past(file_rdata_i, 2) && zero_flag_o == (working_o == 8'h00)) else $error("w");
  a_move_back: assert property (dk && instr_i[13:7] == 7'h11 |-> ##3 file_we_o &&
    file_wdata_o == $past(file_rdata_i, 2) && zero_flag_o == (file_wdata_o == 8'h00))
    else $error("back");
  a_read_pulse: assert property (dk && instr_i[13:8] == 6'h08 |=> file_re_o ##1 !file_re_o)
    else $error("re");
  a_store_w: assert property (dk && instr_i[13:7] == 7'h01 |-> ##3 file_we_o &&
    file_wdata_o == working_o && $stable(zero_flag_o)) else $error("store");
  a_idle_quiet: assert property (dk && (instr_i & 14'h3f9f) == 14'h0000 |=>
    (!file_re_o && !file_we_o && $stable(zero_flag_o))[*3]) else $error("idle");
  a_irq_set: assert property (dk && instr_i == 14'h0009 |-> ##2 global_irq_enable_o)
    else $error("irq enable");
  a_pop_pc: assert property (dk && instr_i == 14'h0009 |-> ##3 stack_pop_o && pc_load_o &&
    pc_o == $past(stack_top_i)) else $error("pop");
  a_iret_idle: assert property (dk && instr_i == 14'h0009 |-> ##5
    (!file_we_o && !file_re_o && !stack_pop_o)[*4]) else $error("2nd");
  cover property (dk && instr_i == 14'h0009);
  cover property (file_we_o);
  cover property (zero_flag_o);
endmodule // mnd_core_chk
bind mnd_core mnd_core_chk u_chk (.*);

// File: verif/mnd_pmem.sv
`timescale 1ns/1ps
// ==========================================
// Program memory, one word per cycle
module mnd_pmem (
  input wire clock_i,
  input wire rst_i,
  output wire [13:0] instr_o
);
  reg [13:0] mem [0:15];
  reg [3:0] idx_q;
  reg [1:0] qtr_q;
  // Advance after the last quarter so the word holds for the whole cycle
  always @(posedge clock_i) begin
    if (rst_i) begin
      idx_q <= 4'h0;
      qtr_q <= 2'h0;
    end else begin
      qtr_q <= qtr_q + 2'h1;
      if (qtr_q == 2'h3) idx_q <= idx_q + 4'h1;
    end
  end
  assign instr_o = mem[idx_q];
endmodule // mnd_pmem

// File: verif/move_nop_interrupt_return_decode_tb_top.sv
`timescale 1ns/1ps
module move_nop_interrupt_return_decode_tb_top;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] rf [0:127];
  wire [13:0] instr;
  wire [6:0] fa;
  wire [7:0] fw, wk;
  wire [12:0] pc;
  wire we, re, z, irq_en, pop, ld, fe;
  integer err_total = 0, compares = 0, cyc = 0;
  mnd_pmem pm (.clock_i(clock_i), .rst_i(rst_i), .instr_o(instr));
  mnd_core dut (.clock_i(clock_i), .rst_i(rst_i), .instr_i(instr), .file_rdata_i(rf[fa]),
    .stack_top_i(13'h1abc), .file_addr_o(fa), .file_wdata_o(fw), .file_we_o(we),
    .file_re_o(re), .working_o(wk), .zero_flag_o(z), .global_irq_enable_o(irq_en),
    .stack_pop_o(pop), .pc_load_o(ld), .pc_o(pc), .phase_o(), .fetch_o(fe));
  always @(posedge clock_i) begin
    if (we) rf[fa] <= fw;
    cyc = cyc + 1;
    if (cyc == 400) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task chk(input [15:0] seen, input [15:0] exp, input [23:0] nm);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task step;
    begin
      repeat (4) @(posedge clock_i);
      #1;
    end
  endtask
  task t_idle(input [7:0] w, input zz);
    begin
      step;
      chk(wk, w, "w");
      chk(z, zz, "z");
      chk(we, 0, "we");
      chk(re, 0, "re");
      chk(fe, 1, "fe");
    end
  endtask
  task t_move;
    begin
      step;
      chk(wk, 8'h5a, "w");
      chk(z, 0, "z");
      step;
      chk({we, fa, fw}, {1'b1, 7'h10, 8'h00}, "wr");
      chk(z, 1, "z");
    end
  endtask
  task t_store;
    begin
      step;
      chk({we, fa, fw}, {1'b1, 7'h12, 8'h5a}, "wr");
      chk(z, 1, "z");
    end
  endtask
  task t_iret;
    begin
      step;
      chk({irq_en, pop, ld}, 3'h7, "pop");
      chk(pc, 13'h1abc, "pc");
      step;
      chk({z, pop, we, wk}, {3'h4, 8'h5a}, "2nd");
      chk(pc, 13'h1abd, "pc");
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    rf[16] = 8'h00;
    rf[17] = 8'h5a;
    pm.mem[0] = 14'h0060;
    pm.mem[1] = 14'h0811;
    pm.mem[2] = 14'h0890;
    pm.mem[3] = 14'h0092;
    pm.mem[4] = 14'h0009;
    pm.mem[5] = 14'h0811;
    pm.mem[6] = 14'h0040;
    repeat (20) @(posedge clock_i);
    #1 rst_i = 1'b0;
    t_idle(8'h00, 1'b0);
    t_move;
    t_store;
    t_iret;
    t_idle(8'h5a, 1'b1);
    wrap_up;
  end
endmodule // move_nop_interrupt_return_decode_tb_top
